/* design/udrt_timer.sv */
// Contract
// RULE1 - mode bit 7 picks interval or reload
// RULE2 - bits 6,5 pick up, down or pin
// RULE3 - direction pin high counts down, low up
// RULE4 - bits 4,3 read one, ignore writes
// RULE5 - bits 2..0 pick the count clock
// RULE6 - code 111 counts chosen event pin edges
// RULE7 - counter read-only, readable without disturbing
// RULE8 - every overflow or underflow sets request flag
// RULE9 - interrupt only when flag and enable set
// RULE10 - wrap on first clock after top/bottom
// RULE11 - interval mode wraps to 00 or ff
// RULE12 - reload write also loads the counter
// RULE13 - reload mode loads reload value on wrap
// RULE14 - reload mode otherwise same as interval
// RULE15 - counter and reload share one address
// RULE16 - reset: count 00, reload 00, mode 18
// RULE17 - software routes event pin before code 111
// RULE18 - software routes direction pin before use
// RULE19 - low power: only subclock or event counts
// RULE20 - subclock source synchronised to system clock
// RULE21 - pins sampled; edges become one-cycle enables
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module udrt_timer (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire udrt_pkg::udrt_axi_req_t axi_req,
	output var  udrt_pkg::udrt_axi_rsp_t axi_rsp,
	input  wire logic [5:0]              prescale_tick,
	input  wire logic                    subclock_div4,
	input  wire logic                    event_input_pin,
	input  wire logic                    count_direction_pin,
	input  wire logic                    event_edge_select,
	input  wire logic                    low_power_mode,
	input  wire logic                    timer_interrupt_enable,
	input  wire logic                    timer_flag_clear,
	output var  logic                    timer_request_flag,
	output var  logic                    timer_irq
);
	import udrt_pkg::*;

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		udrt_axi_rsp_t     rsp;
		logic              aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_held;
		logic [DATA_W-1:0] w_data;
		logic [3:0]        w_strb;
		logic              auto_reload;
		logic              hw_dir;
		logic              sw_down;
		udrt_clk_t         clk_sel;
		logic [7:0]        count;
		logic [7:0]        reload;
		logic              flag;
		logic              irq;
		logic              event_prev;
		logic              sub_prev;
	} udrt_state_t;

	udrt_state_t st_ff;
	udrt_state_t nxt_st;

	logic [2:0] pin_stable;
	logic       event_level;
	logic       sub_level;
	logic       dir_level;
	logic       event_edge;
	logic       sub_edge;
	logic       count_tick;
	logic       count_down;
	logic       wr_fire;
	logic       wr_mode;
	logic       wr_count;
	logic       wr_hit;
	logic       rd_mode;
	logic       rd_count;
	logic [7:0] mode_value;
	logic       at_limit;

	// ************************************************
	// pin sampling
	// ************************************************
	// all three outside signals share one synchroniser
	udrt_pin_sync #(
		.WIDTH (3)
	) u_sync (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_async  ({subclock_div4, count_direction_pin, event_input_pin}),
		.pin_stable (pin_stable)
	);

	assign event_level = pin_stable[0];
	assign dir_level   = pin_stable[1];
	assign sub_level   = pin_stable[2];

	// edges of sampled levels become single-cycle enables
	assign event_edge = event_edge_select ? (event_level & ~st_ff.event_prev)  // RULE6 RULE21
	                                      : (~event_level & st_ff.event_prev);
	assign sub_edge   = sub_level & ~st_ff.sub_prev;                           // RULE20

	// ************************************************
	// count clock and direction
	// ************************************************
	// internal prescaled clocks stop in low power, so only the slow sources remain
	always_comb
	begin
		case (st_ff.clk_sel)                                                   // RULE5
			CLK_SUB4:  count_tick = sub_edge;
			CLK_EVENT: count_tick = event_edge;                                // RULE6 RULE17
			default:   count_tick = prescale_tick[st_ff.clk_sel] & ~low_power_mode; // RULE19
		endcase
	end

	// pin decides when hw control is on, software bit otherwise
	assign count_down = st_ff.hw_dir ? dir_level : st_ff.sw_down;             // RULE2 RULE3 RULE18
	assign at_limit   = count_down ? (st_ff.count == COUNT_BOTTOM)
	                               : (st_ff.count == COUNT_TOP);

	// ************************************************
	// bus decode
	// ************************************************
	assign wr_fire  = st_ff.aw_held & st_ff.w_held & ~st_ff.rsp.bvalid;
	assign wr_hit   = (st_ff.aw_addr[ADDR_W-1:2] == MODE_IDX) ||
	                  (st_ff.aw_addr[ADDR_W-1:2] == COUNT_IDX);
	// a write with lane 0 disabled is answered but changes nothing
	assign wr_mode  = wr_fire & st_ff.w_strb[0] & (st_ff.aw_addr[ADDR_W-1:2] == MODE_IDX);
	assign wr_count = wr_fire & st_ff.w_strb[0] & (st_ff.aw_addr[ADDR_W-1:2] == COUNT_IDX); // RULE15
	assign rd_mode  = axi_req.araddr[ADDR_W-1:2] == MODE_IDX;
	assign rd_count = axi_req.araddr[ADDR_W-1:2] == COUNT_IDX;

	// reserved pair always reads as ones
	assign mode_value = {st_ff.auto_reload, st_ff.hw_dir, st_ff.sw_down,
	                     MODE_RSVD_VAL, st_ff.clk_sel};                       // RULE4

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		nxt_st            = st_ff;
		nxt_st.event_prev = event_level;
		nxt_st.sub_prev   = sub_level;

		// write address and data are captured in either order
		if (axi_req.awvalid && st_ff.rsp.awready)
		begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st_ff.rsp.wready)
		begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = axi_req.wdata;
			nxt_st.w_strb = axi_req.wstrb;
		end
		if (st_ff.rsp.bvalid && axi_req.bready)
			nxt_st.rsp.bvalid = 1'b0;
		if (wr_fire)
		begin
			nxt_st.aw_held    = 1'b0;
			nxt_st.w_held     = 1'b0;
			nxt_st.rsp.bvalid = 1'b1;
			nxt_st.rsp.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// reads never touch the counter, so counting runs on
		if (st_ff.rsp.rvalid && axi_req.rready)
			nxt_st.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && st_ff.rsp.arready)
		begin
			nxt_st.rsp.rvalid = 1'b1;
			nxt_st.rsp.rresp  = (rd_mode || rd_count) ? RESP_OKAY : RESP_SLVERR;
			if (rd_mode)
				nxt_st.rsp.rdata = {24'h000000, mode_value};
			else if (rd_count)
				nxt_st.rsp.rdata = {24'h000000, st_ff.count};                 // RULE7 RULE15
			else
				nxt_st.rsp.rdata = '0;
		end
		nxt_st.rsp.awready = ~nxt_st.aw_held;
		nxt_st.rsp.wready  = ~nxt_st.w_held;
		nxt_st.rsp.arready = ~nxt_st.rsp.rvalid;

		// mode bits; reserved bits are not stored at all
		if (wr_mode)
		begin
			nxt_st.auto_reload = st_ff.w_data[MODE_AUTO_BIT];                 // RULE1
			nxt_st.hw_dir      = st_ff.w_data[MODE_HWDIR_BIT];                // RULE2
			nxt_st.sw_down     = st_ff.w_data[MODE_DOWN_BIT];
			nxt_st.clk_sel     = udrt_clk_t'(st_ff.w_data[MODE_CLK_LO +: 3]); // RULE5
		end

		// a software load beats a count tick in the same cycle
		if (wr_count)
		begin
			nxt_st.reload = st_ff.w_data[7:0];                                // RULE12
			nxt_st.count  = st_ff.w_data[7:0];
		end
		else if (count_tick)
		begin
			if (at_limit)
			begin
				nxt_st.flag = 1'b1;                                           // RULE8 RULE10
				if (st_ff.auto_reload)
					nxt_st.count = st_ff.reload;                              // RULE13 RULE14
				else
					nxt_st.count = count_down ? COUNT_TOP : COUNT_BOTTOM;     // RULE11
			end
			else if (count_down)
				nxt_st.count = st_ff.count - 8'h01;
			else
				nxt_st.count = st_ff.count + 8'h01;
		end

		// a clear loses against a wrap in the same cycle
		if (timer_flag_clear && !(count_tick && at_limit && !wr_count))
			nxt_st.flag = 1'b0;
		nxt_st.irq = st_ff.flag & timer_interrupt_enable;                     // RULE9
	end

	// ************************************************
	// registers
	// ************************************************
	// reset leaves an interval up-counter on the slowest clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff             <= '0;
			st_ff.auto_reload <= MODE_RESET[MODE_AUTO_BIT];                   // RULE16
			st_ff.hw_dir      <= MODE_RESET[MODE_HWDIR_BIT];
			st_ff.sw_down     <= MODE_RESET[MODE_DOWN_BIT];
			st_ff.clk_sel     <= CLK_DIV8192;
			st_ff.count       <= COUNT_RESET;
			st_ff.reload      <= RELOAD_RESET;
		end
		else
			st_ff <= nxt_st;
	end

	assign axi_rsp            = st_ff.rsp;
	assign timer_request_flag = st_ff.flag;
	assign timer_irq          = st_ff.irq;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	reserved_read_a: assert property ( // RULE4
		axi_req.arvalid && axi_rsp.arready && rd_mode |=> axi_rsp.rvalid && axi_rsp.rdata[4:3] == 2'h3)
		else $error("reserved mode bits did not read as ones");

	up_wrap_a: assert property ( // RULE11
		count_tick && !wr_count && !count_down && !st_ff.auto_reload && st_ff.count == 8'hff
		|=> st_ff.count == 8'h00 && timer_request_flag)
		else $error("interval up count did not wrap to zero with flag");

	down_wrap_a: assert property ( // RULE10
		count_tick && !wr_count && count_down && !st_ff.auto_reload && st_ff.count == 8'h00
		|=> st_ff.count == 8'hff && timer_request_flag)
		else $error("interval down count did not wrap to ff with flag");

	reload_wrap_a: assert property ( // RULE13
		count_tick && !wr_count && st_ff.auto_reload && at_limit
		|=> st_ff.count == $past(st_ff.reload))
		else $error("auto reload did not load the reload value");

	load_copy_a: assert property ( // RULE12
		wr_count |=> st_ff.count == $past(st_ff.w_data[7:0]) && st_ff.reload == st_ff.count)
		else $error("reload write did not reach the counter");

	count_hold_a: assert property ( // RULE7
		!count_tick && !wr_count |=> $stable(st_ff.count))
		else $error("counter moved without a count enable");

	low_power_halt_a: assert property ( // RULE19
		low_power_mode && st_ff.clk_sel != CLK_SUB4 && st_ff.clk_sel != CLK_EVENT && !wr_count
		|=> $stable(st_ff.count))
		else $error("internal clock counted in low power");

	pin_down_a: assert property ( // RULE3
		st_ff.hw_dir && dir_level && count_tick && !wr_count && st_ff.count != 8'h00
		|=> st_ff.count == $past(st_ff.count) - 8'h01)
		else $error("direction pin high did not count down");

	irq_gate_a: assert property ( // RULE9
		timer_irq |-> $past(timer_interrupt_enable) && $past(timer_request_flag))
		else $error("interrupt without enable and flag");

	flag_keep_a: assert property ( // RULE8
		count_tick && at_limit && !wr_count && timer_flag_clear |=> timer_request_flag)
		else $error("flag clear lost a wrap");

endmodule
`default_nettype wire

/* design/udrt_pkg.sv */
`default_nettype none
package udrt_pkg;

	// ************************************************
	// bus geometry
	// ************************************************
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;

	// register indices; byte address is the index times four
	localparam logic [29:0] MODE_IDX  = 30'h0000ffb4;
	localparam logic [29:0] COUNT_IDX = 30'h0000ffb5;

	// ************************************************
	// mode register fields and reset values
	// ************************************************
	localparam int unsigned MODE_AUTO_BIT  = 7;
	localparam int unsigned MODE_HWDIR_BIT = 6;
	localparam int unsigned MODE_DOWN_BIT  = 5;
	localparam int unsigned MODE_CLK_LO    = 0;
	localparam logic [1:0]  MODE_RSVD_VAL  = 2'h3;
	localparam logic [7:0]  MODE_RESET     = 8'h18;
	localparam logic [7:0]  COUNT_RESET    = 8'h00;
	localparam logic [7:0]  RELOAD_RESET   = 8'h00;
	localparam logic [7:0]  COUNT_TOP      = 8'hff;
	localparam logic [7:0]  COUNT_BOTTOM   = 8'h00;
	localparam int unsigned NUM_PRESCALE   = 6;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// count clock selection codes
	typedef enum logic [2:0] {
		CLK_DIV8192 = 3'b000,
		CLK_DIV2048 = 3'b001,
		CLK_DIV512  = 3'b010,
		CLK_DIV64   = 3'b011,
		CLK_DIV16   = 3'b100,
		CLK_DIV4    = 3'b101,
		CLK_SUB4    = 3'b110,
		CLK_EVENT   = 3'b111
	} udrt_clk_t;

	// ************************************************
	// axi4-lite carriers
	// ************************************************
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} udrt_axi_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} udrt_axi_rsp_t;

endpackage
`default_nettype wire

/* design/udrt_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module udrt_pin_sync #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] pin_async,
	output var  logic [WIDTH-1:0] pin_stable
);
	import udrt_pkg::*;

	generate
		if (WIDTH < 1)
		begin : g_bad_width
			$error("udrt_pin_sync needs at least one bit");
		end
	endgenerate

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;
	} udrt_sync_state_t;

	udrt_sync_state_t st_ff;
	udrt_sync_state_t nxt_st;

	// three stages; s1 feeds only s2, a change is taken once s2 and s3 agree
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.s1     = pin_async;
		nxt_st.s2     = st_ff.s1;
		nxt_st.s3     = st_ff.s2;
		nxt_st.stable = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.stable);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign pin_stable = st_ff.stable;

endmodule
`default_nettype wire

/* sim/udrt_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// far side: event pin, subclock and direction pin
// ************************************************
module udrt_pin_model (
	input  wire logic aclk,
	input  wire logic ev_go,
	input  wire logic sub_go,
	input  wire logic dir_down,
	output var  logic event_input_pin,
	output var  logic subclock_div4,
	output var  logic count_direction_pin
);
	logic [3:0] ev_cnt_ff = 4'h0;
	logic [3:0] sub_cnt_ff = 4'h0;

	// one pulse per request: high four cycles, then low, so each edge is seen
	always @(posedge aclk)
	begin
		ev_cnt_ff <= ev_go ? 4'h8 : ev_cnt_ff - {3'h0, ev_cnt_ff != 4'h0};
		sub_cnt_ff <= sub_go ? 4'h8 : sub_cnt_ff - {3'h0, sub_cnt_ff != 4'h0};
	end

	// pins stand low between pulses; the direction level is held as asked
	always_comb
	begin
		event_input_pin = ev_cnt_ff > 4'h4;
		subclock_div4 = sub_cnt_ff > 4'h4;
		count_direction_pin = dir_down;
	end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import udrt_pkg::*;
	localparam logic [31:0] A_M = {MODE_IDX, 2'b00};
	localparam logic [31:0] A_C = {COUNT_IDX, 2'b00};
	localparam logic [31:0] A_X = {30'h0000ffb6, 2'b00};
	logic          aclk = 1'b0;
	logic          aresetn;
	udrt_axi_req_t axi_req;
	udrt_axi_rsp_t axi_rsp;
	logic [5:0]    prescale_tick;
	logic          ev_go, sub_go, dir_down, evsel, lp, ien, fclr;
	logic          ev_pin, sub_pin, dir_pin, flag, irq;
	int            errors = 0;
	int            checks_done = 0;

	// ************************************************
	// clock, design and far side
	// ************************************************
	always #10 aclk = ~aclk;

	udrt_timer udrt_timer_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .prescale_tick(prescale_tick), .subclock_div4(sub_pin),
		.event_input_pin(ev_pin), .count_direction_pin(dir_pin),
		.event_edge_select(evsel), .low_power_mode(lp), .timer_interrupt_enable(ien),
		.timer_flag_clear(fclr), .timer_request_flag(flag), .timer_irq(irq));

	udrt_pin_model udrt_pin_model_inst (.aclk(aclk), .ev_go(ev_go), .sub_go(sub_go),
		.dir_down(dir_down), .event_input_pin(ev_pin), .subclock_div4(sub_pin),
		.count_direction_pin(dir_pin));

	// ************************************************
	// helpers
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// bready and rready stay high, so only the request channels move here
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= {24'h0, d};
		for (int n = 0; n < 100 && !done; n++)
		begin
			@(posedge aclk);
			if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid === 1'b1)
			begin
				done = 1'b1;
				chk({30'h0, axi_rsp.bresp}, {30'h0, er});
			end
		end
		chk({31'h0, done}, 32'h1);
	endtask

	task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
		logic done;
		done = 1'b0;
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		for (int n = 0; n < 100 && !done; n++)
		begin
			@(posedge aclk);
			if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid === 1'b1)
			begin
				done = 1'b1;
				chk(axi_rsp.rdata, {24'h0, e});
				chk({30'h0, axi_rsp.rresp}, {30'h0, er});
			end
		end
		chk({31'h0, done}, 32'h1);
	endtask

	// one-cycle pulse on one prescaler output
	task automatic tick(input int k);
		prescale_tick <= 6'h01 << k;
		@(posedge aclk);
		prescale_tick <= 6'h00;
	endtask

	// look at the flag, then clear it for the next case
	task automatic fchk(input logic e);
		wt(3);
		chk({31'h0, flag}, {31'h0, e});
		fclr <= 1'b1;
		@(posedge aclk);
		fclr <= 1'b0;
	endtask

	// ************************************************
	// tests
	// ************************************************
	initial
	begin
		aresetn = 1'b0;
		axi_req = '0;
		axi_req.wstrb = 4'hf;
		axi_req.bready = 1'b1;
		axi_req.rready = 1'b1;
		prescale_tick = 6'h00;
		{ev_go, sub_go, dir_down, evsel, lp, ien, fclr} = 7'h00;
		wt(20);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_M, 8'h18, RESP_OKAY);
		rd(A_C, 8'h00, RESP_OKAY);
		wr(A_M, 8'he7, RESP_OKAY);
		rd(A_M, 8'hff, RESP_OKAY);
		wr(A_M, 8'h00, RESP_OKAY);
		rd(A_M, 8'h18, RESP_OKAY);
		wr(A_X, 8'h55, RESP_SLVERR);
		rd(A_X, 8'h00, RESP_SLVERR);
		// lane 0 off: answered, but the mode must stay as it was
		axi_req.wstrb <= 4'h0;
		wr(A_M, 8'h85, RESP_OKAY);
		axi_req.wstrb <= 4'hf;
		rd(A_M, 8'h18, RESP_OKAY);
		// each code follows its own prescaler and ignores the next one up
		for (int k = 0; k < 6; k++)
		begin
			wr(A_M, 8'h18 | 8'(k), RESP_OKAY);
			wr(A_C, 8'h10, RESP_OKAY);
			tick((k + 1) % 6);
			rd(A_C, 8'h10, RESP_OKAY);
			tick(k);
			rd(A_C, 8'h11, RESP_OKAY);
			rd(A_C, 8'h11, RESP_OKAY);
		end
		// interval wraps, flag and interrupt masking
		ien <= 1'b1;
		wr(A_M, 8'h05, RESP_OKAY);
		wr(A_C, 8'hfe, RESP_OKAY);
		tick(5);
		wt(3);
		chk({31'h0, flag}, 32'h0);
		tick(5);
		wt(3);
		chk({30'h0, flag, irq}, 32'h3);
		rd(A_C, 8'h00, RESP_OKAY);
		ien <= 1'b0;
		wt(3);
		chk({30'h0, flag, irq}, 32'h2);
		fchk(1'b1);
		// wrap and clear in one cycle: the wrap must win
		wr(A_C, 8'hff, RESP_OKAY);
		fclr <= 1'b1;
		tick(5);
		fclr <= 1'b0;
		fchk(1'b1);
		wr(A_M, 8'h25, RESP_OKAY);
		wr(A_C, 8'h00, RESP_OKAY);
		tick(5);
		fchk(1'b1);
		rd(A_C, 8'hff, RESP_OKAY);
		// auto reload, both directions, shortest period
		wr(A_M, 8'h85, RESP_OKAY);
		wr(A_C, 8'hff, RESP_OKAY);
		tick(5);
		fchk(1'b1);
		rd(A_C, 8'hff, RESP_OKAY);
		wr(A_M, 8'ha5, RESP_OKAY);
		wr(A_C, 8'h01, RESP_OKAY);
		tick(5);
		rd(A_C, 8'h00, RESP_OKAY);
		tick(5);
		fchk(1'b1);
		rd(A_C, 8'h01, RESP_OKAY);
		// direction from the pin; the software bit is then ignored
		wr(A_M, 8'h45, RESP_OKAY);
		dir_down <= 1'b1;
		wt(8);
		wr(A_C, 8'h80, RESP_OKAY);
		tick(5);
		rd(A_C, 8'h7f, RESP_OKAY);
		dir_down <= 1'b0;
		wt(8);
		wr(A_M, 8'h65, RESP_OKAY);
		wr(A_C, 8'h80, RESP_OKAY);
		tick(5);
		rd(A_C, 8'h81, RESP_OKAY);
		// event edges, rising then falling
		for (int es = 1; es >= 0; es--)
		begin
			evsel <= es[0];
			wr(A_M, 8'h07, RESP_OKAY);
			wr(A_C, 8'h20, RESP_OKAY);
			ev_go <= 1'b1;
			@(posedge aclk);
			ev_go <= 1'b0;
			wt(20);
			rd(A_C, 8'h21, RESP_OKAY);
		end
		// low power: prescaler halted, subclock still counts
		lp <= 1'b1;
		wr(A_M, 8'h05, RESP_OKAY);
		wr(A_C, 8'h40, RESP_OKAY);
		tick(5);
		rd(A_C, 8'h40, RESP_OKAY);
		wr(A_M, 8'h06, RESP_OKAY);
		sub_go <= 1'b1;
		@(posedge aclk);
		sub_go <= 1'b0;
		wt(20);
		rd(A_C, 8'h41, RESP_OKAY);
		lp <= 1'b0;
		conclude();
	end

	// a hang counts as a mismatch
	initial
	begin
		wt(20000);
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
